// File: logic/pcr_pkg.sv
// constants, field layout and state types of the port configuration block
// What this block does
// R1 - force-link bit makes link report pass
// R2 - transmit-disable bit turns transmitter off
// R3 - scrambler-bypass skips scrambler and descrambler
// R4 - jabber bit disables jabber correction
// R5 - heartbeat bit enables collision heartbeat; code sends it only at 10 Mbps
// R6 - loopback bit stops half-duplex echo
// R7 - carrier-select stretches CRS until RX_DV drops; code stretches only at 10 Mbps
// R8 - preamble off: RX_DV rises with SFD
// R9 - preamble on: RX_DV rises with CRS
// R10 - at 100 Mbps preamble always passed
// R11 - alternate page bit gates capability
// R12 - software writes reserved bits as zero
// R13 - config at index 16, status 17
// R14 - writes act at once; reset restores defaults
package pcr_pkg;
    localparam logic [5:0] CFG_IDX = 6'h10;
    localparam logic [5:0] STS_IDX = 6'h11;
    localparam int ADR_LSB = 2;
    localparam logic [15:0] CFG_RESET = 16'h0080;
    localparam logic [15:0] CFG_WMASK = 16'h77a2;
    localparam int B_FORCE_LINK = 14;
    localparam int B_TX_DISABLE = 13;
    localparam int B_SCR_BYPASS = 12;
    localparam int B_JABBER_OFF = 10;
    localparam int B_HEARTBEAT = 9;
    localparam int B_LOOP_OFF = 8;
    localparam int B_CRS_SEL = 7;
    localparam int B_PRE_EN = 5;
    localparam int B_ALT_PAGE = 1;
    localparam int S_SPEED_100 = 14;
    localparam int S_TX_ACTIVE = 13;
    localparam int S_RX_ACTIVE = 12;
    localparam logic [3:0] SFD_NIBBLE = 4'hd;
    localparam logic [10:0] LFSR_SEED = 11'h7ff;
    localparam int JAB_W = 16;
    localparam int HB_W = 8;
    localparam int SYNC_W = 9;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_PRE = 2'b01,
        RX_DATA = 2'b10
    } pcr_rx_e_t;

    typedef enum logic [1:0] {
        HB_IDLE = 2'b00,
        HB_WAIT = 2'b01,
        HB_PULSE = 2'b10
    } pcr_hb_e_t;

    typedef struct packed {
        pcr_rx_e_t st;
        logic dv;
        logic [3:0] rxd;
    } pcr_rx_state_t;

    typedef struct packed {
        logic [15:0] cfg;
        logic ack;
        logic [31:0] dat;
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [10:0] tx_lfsr;
        logic [10:0] rx_lfsr;
        logic tx_on;
        logic [3:0] twisted_pair_txd;
        logic tx_en_d;
        logic [JAB_W-1:0] jab_cnt;
        logic jabber;
        pcr_hb_e_t hb;
        logic [HB_W-1:0] hb_cnt;
        logic crs;
        logic col;
    } pcr_top_state_t;
endpackage : pcr_pkg

// File: logic/pcr_rx_present.sv
// receive presentation: decides where RX_DV rises relative to preamble and SFD
`timescale 1ns/1ps
module pcr_rx_present (
    input wire logic clk,
    input wire logic rst,
    input wire logic carrier,
    input wire logic [3:0] nibble,
    input wire logic pass_preamble,
    output logic rx_dv,
    output logic [3:0] rxd
);
    pcr_pkg::pcr_rx_state_t q;
    pcr_pkg::pcr_rx_state_t next_q;

    always_comb begin
        next_q = q;
        next_q.dv = 1'b0;
        next_q.rxd = 4'h0;
        case (q.st)
            pcr_pkg::RX_IDLE, pcr_pkg::RX_PRE: begin
                if (!carrier) begin
                    next_q.st = pcr_pkg::RX_IDLE;
                end else if (nibble == pcr_pkg::SFD_NIBBLE) begin
                    // R8 sfd opens frame
                    next_q.st = pcr_pkg::RX_DATA;
                    next_q.dv = 1'b1;
                    next_q.rxd = nibble;
                end else begin
                    // R9 preamble shown with carrier
                    next_q.st = pcr_pkg::RX_PRE;
                    next_q.dv = pass_preamble;
                    next_q.rxd = pass_preamble ? nibble : 4'h0;
                end
            end
            pcr_pkg::RX_DATA: begin
                if (!carrier) begin
                    next_q.st = pcr_pkg::RX_IDLE;
                end else begin
                    next_q.dv = 1'b1;
                    next_q.rxd = nibble;
                end
            end
            default: begin
                next_q.st = pcr_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{st: pcr_pkg::RX_IDLE, dv: 1'b0, rxd: 4'h0};
        end else begin
            q <= next_q;
        end
    end

    assign rx_dv = q.dv;
    assign rxd = q.rxd;
endmodule : pcr_rx_present

// File: logic/pcr_top.sv
// port configuration register with its wishbone slave and the mii paths it steers
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module pcr_top #(
    parameter logic [15:0] JABBER_LIMIT = 16'd4000,
    parameter logic [7:0] HB_DELAY = 8'd40,
    parameter logic [7:0] HB_LEN = 8'd40
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic ACK_O,
    output logic [31:0] DAT_O,
    input wire logic TX_EN,
    input wire logic [3:0] TXD,
    output logic RX_DV,
    output logic [3:0] RXD,
    output logic CRS,
    output logic COL,
    input wire logic LINK_DETECT,
    input wire logic LINE_CARRIER,
    input wire logic [3:0] LINE_RXD,
    input wire logic LINE_COLLISION,
    input wire logic SPEED_100,
    input wire logic FULL_DUPLEX,
    output logic TWISTED_PAIR_TX_ON,
    output logic [3:0] TWISTED_PAIR_TXD,
    output logic LINK_OK,
    output logic ANEG_ALT_PAGE_CAP
);
    pcr_pkg::pcr_top_state_t q;
    pcr_pkg::pcr_top_state_t next_q;

    // sync bundle layout, pins only
    localparam int SY_LINK = 0;
    localparam int SY_CARR = 1;
    localparam int SY_RXD = 2;
    localparam int SY_COL = 6;
    localparam int SY_SPD = 7;
    localparam int SY_FDX = 8;
    localparam int ADR_LSB_HI = 7;

    // advance x^11+x^9+1 four steps; key nibble in low bits
    function automatic logic [14:0] lfsr4(input logic [10:0] s);
        logic [10:0] t;
        logic [3:0] k;
        t = s;
        k = 4'h0;
        for (int i = 0; i < 4; i++) begin
            k[i] = t[10] ^ t[8];
            t = {t[9:0], k[i]};
        end
        return {t, k};
    endfunction : lfsr4

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [15:0] wr,
        input logic [1:0] sel
    );
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wr[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wr[15:8];
        end
        return r;
    endfunction : merge16

    logic wb_req;
    logic [5:0] reg_idx;
    logic speed_100;
    logic full_dup;
    logic [14:0] tx_step;
    logic [14:0] rx_step;
    logic scramble_on;
    logic lb_echo;
    logic rx_carrier;
    logic [3:0] rx_nibble;
    logic pre_pass;
    logic pres_dv;
    logic [3:0] pres_rxd;
    logic tx_fall;
    logic [15:0] sts;
    logic link_pass;

    assign wb_req = CYC_I & STB_I;
    assign reg_idx = ADR_I[ADR_LSB_HI:pcr_pkg::ADR_LSB];
    assign speed_100 = q.s2[SY_SPD];
    assign full_dup = q.s2[SY_FDX];
    assign tx_step = lfsr4(q.tx_lfsr);
    assign rx_step = lfsr4(q.rx_lfsr);

    // R3 scrambling only at 100
    assign scramble_on = speed_100 & ~q.cfg[pcr_pkg::B_SCR_BYPASS];

    // R6 half-duplex 10 echo unless disabled
    assign lb_echo = ~speed_100 & ~full_dup & TX_EN & ~q.cfg[pcr_pkg::B_LOOP_OFF];

    assign rx_carrier = lb_echo | q.s2[SY_CARR];

    // R3 descrambler bypass
    always_comb begin
        if (lb_echo) begin
            rx_nibble = TXD;
        end else if (scramble_on) begin
            rx_nibble = q.s2[SY_RXD +: 4] ^ rx_step[3:0];
        end else begin
            rx_nibble = q.s2[SY_RXD +: 4];
        end
    end

    // R10 preamble forced at 100
    assign pre_pass = q.cfg[pcr_pkg::B_PRE_EN] | speed_100;

    pcr_rx_present u_present (
        .clk(CLOCK),
        .rst(RST),
        .carrier(rx_carrier),
        .nibble(rx_nibble),
        .pass_preamble(pre_pass),
        .rx_dv(pres_dv),
        .rxd(pres_rxd)
    );

    // R1 forced link pass
    assign link_pass = q.cfg[pcr_pkg::B_FORCE_LINK] | q.s2[SY_LINK];

    assign tx_fall = q.tx_en_d & ~TX_EN;

    always_comb begin
        sts = 16'h0000;
        sts[pcr_pkg::S_SPEED_100] = speed_100;
        sts[pcr_pkg::S_TX_ACTIVE] = q.tx_on;
        sts[pcr_pkg::S_RX_ACTIVE] = pres_dv;
    end

    always_comb begin
        next_q = q;
        // pin synchronisers: stage one feeds stage two only
        next_q.s1 = {FULL_DUPLEX, SPEED_100, LINE_COLLISION, LINE_RXD, LINE_CARRIER,
            LINK_DETECT};
        next_q.s2 = q.s1;

        // classic wishbone: ack one cycle after request, dropped the next
        next_q.ack = wb_req & ~q.ack;
        if (wb_req & ~q.ack) begin
            // R13 register decode
            case (reg_idx)
                pcr_pkg::CFG_IDX: begin
                    // R12 reserved bits read zero
                    next_q.dat = {16'h0000, q.cfg & pcr_pkg::CFG_WMASK};
                end
                pcr_pkg::STS_IDX: begin
                    next_q.dat = {16'h0000, sts};
                end
                default: begin
                    next_q.dat = 32'h0000_0000;
                end
            endcase
        end
        // R14 write lands on the acked edge
        if (wb_req & q.ack & WE_I & (reg_idx == pcr_pkg::CFG_IDX)) begin
            // R12 reserved bits not stored
            next_q.cfg = merge16(q.cfg, DAT_I[15:0], SEL_I[1:0]) & pcr_pkg::CFG_WMASK;
        end

        // transmit path
        next_q.tx_en_d = TX_EN;
        next_q.tx_lfsr = tx_step[14:4];
        next_q.rx_lfsr = rx_step[14:4];
        // R3 scrambler bypass
        next_q.twisted_pair_txd = scramble_on ? (TXD ^ tx_step[3:0]) : TXD;

        // R4 jabber cut in 10 only, unless disabled
        if (!TX_EN || speed_100) begin
            next_q.jab_cnt = '0;
            next_q.jabber = 1'b0;
        end else if (q.jab_cnt >= JABBER_LIMIT) begin
            next_q.jabber = ~q.cfg[pcr_pkg::B_JABBER_OFF];
        end else begin
            next_q.jab_cnt = q.jab_cnt + 16'd1;
        end

        // R2 transmitter disable
        next_q.tx_on = TX_EN & ~q.cfg[pcr_pkg::B_TX_DISABLE] & ~next_q.jabber;

        // R5 heartbeat after transmit in 10
        case (q.hb)
            pcr_pkg::HB_IDLE: begin
                next_q.hb_cnt = '0;
                if (tx_fall & ~speed_100 & q.cfg[pcr_pkg::B_HEARTBEAT]) begin
                    next_q.hb = pcr_pkg::HB_WAIT;
                end
            end
            pcr_pkg::HB_WAIT: begin
                if (q.hb_cnt + 8'd1 >= HB_DELAY) begin
                    next_q.hb_cnt = '0;
                    next_q.hb = pcr_pkg::HB_PULSE;
                end else begin
                    next_q.hb_cnt = q.hb_cnt + 8'd1;
                end
            end
            pcr_pkg::HB_PULSE: begin
                if (q.hb_cnt + 8'd1 >= HB_LEN) begin
                    next_q.hb = pcr_pkg::HB_IDLE;
                end
                next_q.hb_cnt = q.hb_cnt + 8'd1;
            end
            default: begin
                next_q.hb = pcr_pkg::HB_IDLE;
            end
        endcase
        next_q.col = q.s2[SY_COL] | (next_q.hb == pcr_pkg::HB_PULSE);

        // R7 crs held until rx_dv drops in 10
        next_q.crs = rx_carrier
            | (~speed_100 & q.cfg[pcr_pkg::B_CRS_SEL] & pres_dv);
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            // R14 defaults on reset
            q <= '{cfg: pcr_pkg::CFG_RESET, ack: 1'b0, dat: 32'h0000_0000,
                s1: '0, s2: '0, tx_lfsr: pcr_pkg::LFSR_SEED,
                rx_lfsr: pcr_pkg::LFSR_SEED, tx_on: 1'b0, twisted_pair_txd: 4'h0,
                tx_en_d: 1'b0, jab_cnt: '0, jabber: 1'b0, hb: pcr_pkg::HB_IDLE,
                hb_cnt: '0, crs: 1'b0, col: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign ACK_O = q.ack;
    assign DAT_O = q.dat;
    assign RX_DV = pres_dv;
    assign RXD = pres_rxd;
    assign CRS = q.crs;
    assign COL = q.col;
    assign TWISTED_PAIR_TX_ON = q.tx_on;
    assign TWISTED_PAIR_TXD = q.twisted_pair_txd;
    assign LINK_OK = link_pass;
    // R11 alternate page capability gate
    assign ANEG_ALT_PAGE_CAP = q.cfg[pcr_pkg::B_ALT_PAGE];
endmodule : pcr_top

// File: tb/pcr_assertions.sv
// concurrent checks on the port configuration block ports
`timescale 1ns/1ps
module pcr_assertions (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic ACK_O,
    input wire logic [31:0] DAT_O,
    input wire logic TWISTED_PAIR_TX_ON,
    input wire logic LINK_OK,
    input wire logic ANEG_ALT_PAGE_CAP
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence req_s; CYC_I && STB_I && !ACK_O; endsequence
    sequence cfg_wr_s; CYC_I && STB_I && WE_I && ADR_I == 8'h40 && ACK_O; endsequence
    sequence rd_s; CYC_I && STB_I && !WE_I && ACK_O; endsequence
    ack_answer_a: assert property (req_s |=> ACK_O) else $error("ack late");
    ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
    force_link_a: assert property (cfg_wr_s ##0 (SEL_I[1] && DAT_I[14]) |=> LINK_OK)
        else $error("link not forced");
    tx_disable_a: assert property (cfg_wr_s ##0 (SEL_I[1] && DAT_I[13]) |-> ##2 !TWISTED_PAIR_TX_ON)
        else $error("transmitter still on");
    alt_page_a: assert property (cfg_wr_s ##0 SEL_I[0] |=> ANEG_ALT_PAGE_CAP == $past(DAT_I[1]))
        else $error("alt page cap wrong");
    cfg_read_a: assert property (rd_s ##0 ADR_I == 8'h40 |-> (DAT_O & 32'hffff885d) == 32'h0)
        else $error("reserved bits read set");
    sts_read_a: assert property (rd_s ##0 ADR_I == 8'h44 |-> DAT_O[31:15] == 17'h0)
        else $error("status upper bits set");
    reset_clear_a: assert property (disable iff (1'b0) RST |-> !ANEG_ALT_PAGE_CAP && !ACK_O)
        else $error("outputs not cleared in reset");
endmodule : pcr_assertions

bind pcr_top pcr_assertions u_chk (.CLOCK(CLOCK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .ACK_O(ACK_O), .DAT_O(DAT_O),
    .TWISTED_PAIR_TX_ON(TWISTED_PAIR_TX_ON), .LINK_OK(LINK_OK),
    .ANEG_ALT_PAGE_CAP(ANEG_ALT_PAGE_CAP));

// File: tb/pcr_mac_model.sv
// mac transmit side: sends a counted burst of nibbles on request
`timescale 1ns/1ps
module pcr_mac_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [7:0] len,
    output logic tx_en,
    output logic [3:0] txd,
    output logic busy
);
    logic [7:0] cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_en <= 1'b0;
            txd <= 4'h0;
            busy <= 1'b0;
            cnt <= 8'h0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            cnt <= len;
        end else if (busy && cnt != 8'h0) begin
            tx_en <= 1'b1;
            txd <= cnt[3:0];
            cnt <= cnt - 8'h1;
        end else begin
            // idle data toggles so stale nibbles cannot pass as valid
            busy <= 1'b0;
            tx_en <= 1'b0;
            txd <= ~txd;
        end
    end
endmodule : pcr_mac_model

// File: tb/testbench.sv
// register, mii receive-path and transmit-path tests for the port configuration block
`timescale 1ns/1ps
module testbench;
    logic CLOCK, RST, CYC_I, STB_I, WE_I, LINK_DETECT, LINE_CARRIER, LINE_COLLISION;
    logic SPEED_100, FULL_DUPLEX, go, TX_EN, RX_DV, CRS, COL, LINK_OK, ANEG, ACK_O, busy;
    logic TWISTED_PAIR_TX_ON, seen_dv, seen_col;
    logic [7:0] ADR_I, len;
    logic [3:0] SEL_I, TXD, RXD, TWISTED_PAIR_TXD, LINE_RXD;
    logic [15:0] cfg_w;
    logic [31:0] DAT_I, DAT_O, q;
    int num_errors = 0;
    int cmp_count = 0;
    pcr_top #(.JABBER_LIMIT(16'd20), .HB_DELAY(8'd4), .HB_LEN(8'd4)) uut (.CLOCK(CLOCK),
        .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
        .DAT_I(DAT_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .TX_EN(TX_EN), .TXD(TXD), .RX_DV(RX_DV),
        .RXD(RXD), .CRS(CRS), .COL(COL), .LINK_DETECT(LINK_DETECT), .LINE_CARRIER(LINE_CARRIER),
        .LINE_RXD(LINE_RXD), .LINE_COLLISION(LINE_COLLISION), .SPEED_100(SPEED_100),
        .FULL_DUPLEX(FULL_DUPLEX), .TWISTED_PAIR_TX_ON(TWISTED_PAIR_TX_ON),
        .TWISTED_PAIR_TXD(TWISTED_PAIR_TXD), .LINK_OK(LINK_OK), .ANEG_ALT_PAGE_CAP(ANEG));
    pcr_mac_model mac (.clk(CLOCK), .rst(RST), .go(go), .len(len), .tx_en(TX_EN), .txd(TXD),
        .busy(busy));
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    task test_done;
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLOCK);
        {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} <= {2'b11, we, a, 4'h3, d};
        do begin
            @(posedge CLOCK);
            n++;
        end while (ACK_O !== 1'b1 && n < 20);
        if (ACK_O !== 1'b1) begin
            num_errors++;
            test_done();
        end
        q = DAT_O;
        {CYC_I, STB_I} <= 2'b00;
        // write lands on the ack edge; callers look one edge later
        @(posedge CLOCK);
    endtask : wb
    // one received frame; checks the nibble shown when RX_DV first rises
    task frame(input logic [15:0] cfg, input logic spd, input logic [3:0] first);
        int n;
        wb(1'b1, 8'h40, {16'h0, cfg});
        SPEED_100 <= spd;
        repeat (4) @(posedge CLOCK);
        fork
            begin
                LINE_CARRIER <= 1'b1;
                LINE_RXD <= 4'h5;
                repeat (6) @(posedge CLOCK);
                LINE_RXD <= 4'hd;
                @(posedge CLOCK);
                LINE_RXD <= 4'ha;
                repeat (3) @(posedge CLOCK);
                {LINE_CARRIER, LINE_RXD} <= {1'b0, 4'h5};
            end
            begin
                n = 0;
                do begin
                    @(posedge CLOCK);
                    n++;
                end while (RX_DV !== 1'b1 && n < 30);
                if (RX_DV !== 1'b1) begin
                    num_errors++;
                    test_done();
                end
                chk(RXD, first);
                while (RX_DV === 1'b1 && n < 60) begin
                    if (cfg[7] && !spd) chk(CRS, 1'b1);
                    @(posedge CLOCK);
                    n++;
                end
                if (RX_DV === 1'b1) begin
                    num_errors++;
                    test_done();
                end
                // carrier already gone: only the stretch keeps crs up here
                chk(CRS, cfg[7] && !spd);
            end
        join
    endtask : frame
    initial begin
        {CYC_I, STB_I, WE_I, ADR_I, DAT_I, SEL_I} = {3'b000, 8'h0, 32'h0, 4'h3};
        {LINK_DETECT, LINE_CARRIER, LINE_COLLISION, LINE_RXD, go} = 8'h0;
        {SPEED_100, FULL_DUPLEX, len} = {2'b01, 8'd8};
        // low first so the reset flops see a real rising edge
        RST = 1'b0;
        #1;
        RST = 1'b1;
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0080);
        wb(1'b1, 8'h40, 32'h77a2);
        chk({LINK_OK, ANEG}, 2'b11);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h77a2);
        wb(1'b1, 8'h48, 32'hffff);
        wb(1'b0, 8'h48, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 8'h40, 32'h0);
        chk({LINK_OK, ANEG}, 2'b00);
        SPEED_100 <= 1'b1;
        repeat (4) @(posedge CLOCK);
        wb(1'b0, 8'h44, 32'h0);
        chk(q[31:14], 18'h1);
        frame(16'h0080, 1'b0, 4'hd);
        frame(16'h00a0, 1'b0, 4'h5);
        frame(16'h1000, 1'b1, 4'h5);
        SPEED_100 <= 1'b0;
        FULL_DUPLEX <= 1'b0;
        // echo with heartbeat, transmitter disable, then jabber cut on and off
        for (int i = 0; i < 4; i++) begin
            cfg_w = (i == 0) ? 16'h02a0 : (i == 1) ? 16'h21a0 : (i == 2) ? 16'h0080 : 16'h0480;
            len <= (i < 2) ? 8'd8 : 8'd30;
            wb(1'b1, 8'h40, {16'h0, cfg_w});
            repeat (4) @(posedge CLOCK);
            go <= 1'b1;
            @(posedge CLOCK);
            go <= 1'b0;
            // look two nibbles before the burst ends
            repeat (len - 8'd2) @(posedge CLOCK);
            chk(TWISTED_PAIR_TX_ON, !cfg_w[13] && (i < 2 || cfg_w[10]));
            chk(TWISTED_PAIR_TXD, 4'h5);
            {seen_dv, seen_col} = 2'b00;
            repeat (12) begin
                @(posedge CLOCK);
                if (RX_DV === 1'b1) seen_dv = 1'b1;
                if (COL === 1'b1) seen_col = 1'b1;
            end
            chk(seen_dv, !cfg_w[8]);
            chk(seen_col, cfg_w[9]);
        end
        RST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0080);
        test_done();
    end
endmodule : testbench
